// [logic/sifid_pkg.sv]
// Constants, field positions and types of the system interface identifier and error block
package sifid_pkg;

	// ****************
	// Register map
	// ****************
	localparam logic [35:0] SIFID_MODE_ADDR = 36'hFFF100000;
	localparam logic [35:0] SIFID_STAT_ADDR = 36'hFFF100004;
	localparam logic [19:0] SIFID_MODE_RESET = 20'hFFFF0;
	localparam logic [11:0] SIFID_MODE_TOP_READ = 12'hFFF;
	localparam int SIFID_RATE_BIT = 0;
	localparam int SIFID_WMODE_LO = 1;
	localparam int SIFID_WMODE_HI = 2;

	// ****************
	// Command and identifier layout
	// ****************
	localparam int SIFID_BIT_IDENT = 8;
	localparam int SIFID_BIT_FINAL = 7;
	localparam int SIFID_BIT_RESP = 6;
	localparam int SIFID_BIT_ERR = 5;
	localparam int SIFID_BIT_CHKEN = 4;
	localparam logic [2:0] SIFID_TYPE_READ = 3'h0;
	localparam logic [2:0] SIFID_TYPE_WRITE = 3'h2;
	localparam logic [2:0] SIFID_TYPE_NULL = 3'h3;
	localparam logic [1:0] SIFID_PROP_BLOCK = 2'h2;
	localparam logic [1:0] SIFID_PROP_WORD = 2'h3;
	localparam logic [1:0] SIFID_PROP_RELEASE = 2'h0;
	localparam logic [2:0] SIFID_BLOCK_CODE = 3'h1;
	localparam logic [2:0] SIFID_LAST_BEAT = 3'h7;
	localparam logic [1:0] SIFID_GAP_LAST = 2'h1;

	// ****************
	// Request sizes and states
	// ****************
	localparam logic [1:0] SIFID_SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIFID_SIZE_HALF = 2'h1;
	localparam logic [1:0] SIFID_SIZE_TRI = 2'h2;
	localparam logic [1:0] SIFID_SIZE_WORD = 2'h3;

	typedef enum logic [1:0] {
		SIFID_TX_IDLE = 2'b00,
		SIFID_TX_CMD = 2'b01,
		SIFID_TX_DATA = 2'b10,
		SIFID_TX_GAP = 2'b11
	} sifid_tx_state_type;

endpackage : sifid_pkg

// [logic/sifid_parity.sv]
// Even parity per byte, used as the check bits of a data beat
`timescale 1ns/1ps
module sifid_parity (
	input wire logic [31:0] data,
	output logic [3:0] check
);
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_byte
			assign check[i] = ^data[8*i +: 8];
		end
	endgenerate
endmodule : sifid_parity

// [logic/sifid_align.sv]
// Address alignment of a processor request by its size
`timescale 1ns/1ps
module sifid_align (
	input wire logic [31:0] addr,
	input wire logic block,
	input wire logic [1:0] size,
	output logic [31:0] aligned
);
	logic word_like;
	logic half;

	assign word_like = block | (size == sifid_pkg::SIFID_SIZE_WORD);
	assign half = ~block & (size == sifid_pkg::SIFID_SIZE_HALF);
	// Single byte and tri-byte requests keep the full byte address
	assign aligned = word_like ? {addr[31:2], 2'b00} : (half ? {addr[31:1], 1'b0} : addr);
endmodule : sifid_align

// [logic/sifid_top.sv]
// System interface identifier coding, alignment, mode register and data error handling
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module sifid_top (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [35:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_WRITE,
	input wire logic REQ_BLOCK,
	input wire logic [1:0] REQ_SIZE,
	input wire logic [31:0] REQ_ADDR,
	input wire logic [31:0] WDATA_IN,
	input wire logic WDATA_PERR,
	output logic WDATA_TAKE,
	output logic [1:0] WRITE_MODE,
	input wire logic VALID_IN_N,
	input wire logic [8:0] CMD_IN,
	input wire logic [31:0] AD_IN,
	input wire logic [3:0] CHK_IN,
	output logic VALID_OUT_N,
	output logic [8:0] CMD_OUT,
	output logic CMD_OE,
	output logic [31:0] AD_OUT,
	output logic AD_OE,
	output logic [3:0] CHK_OUT,
	output logic CHK_OE,
	output logic RX_VALID,
	output logic [31:0] RX_DATA,
	output logic RX_LAST,
	output logic RX_RESP,
	output logic BUS_ERR,
	output logic LINE_INVALID,
	output logic IF_RELEASE
);

	// ****************
	// Register port
	// ****************
	logic [19:0] mode_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic sel_mode;
	logic sel_stat;
	logic rx_block_reg;
	sifid_pkg::sifid_tx_state_type state_reg;
	sifid_pkg::sifid_tx_state_type state_next;

	assign sel_mode = (REG_ADDR == sifid_pkg::SIFID_MODE_ADDR);
	assign sel_stat = (REG_ADDR == sifid_pkg::SIFID_STAT_ADDR);
	// Upper reserved field is not stored; it reads back as all ones
	assign rdata_next = sel_mode ? {sifid_pkg::SIFID_MODE_TOP_READ, mode_reg} :
		(sel_stat ? {30'h0, rx_block_reg, state_reg != sifid_pkg::SIFID_TX_IDLE} : 32'h00000000);

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			mode_reg <= sifid_pkg::SIFID_MODE_RESET;
		end else if (REG_WR && sel_mode) begin
			mode_reg <= REG_WDATA[19:0];
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			rdata_reg <= 32'h00000000;
		end else if (REG_RD) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 32'h00000000;
		end
	end

	assign REG_RDATA = rdata_reg;
	// Single-write protocol choice is handed to the request sequencer outside
	assign WRITE_MODE = mode_reg[sifid_pkg::SIFID_WMODE_HI:sifid_pkg::SIFID_WMODE_LO];

	// ****************
	// Request sequencer
	// ****************
	logic req_write_reg;
	logic req_block_reg;
	logic [1:0] req_size_reg;
	logic [31:0] addr_reg;
	logic [31:0] addr_aligned;
	logic [2:0] beat_reg;
	logic [1:0] gap_reg;
	logic paced;
	logic last_beat;
	logic [3:0] tx_check;
	logic [1:0] cmd_prop;
	logic [2:0] cmd_size;
	logic [8:0] cmd_word;
	logic [8:0] ident_word;

	sifid_align u_align (
		.addr(REQ_ADDR),
		.block(REQ_BLOCK),
		.size(REQ_SIZE),
		.aligned(addr_aligned)
	);

	sifid_parity u_tx_parity (
		.data(WDATA_IN),
		.check(tx_check)
	);

	assign paced = req_block_reg & mode_reg[sifid_pkg::SIFID_RATE_BIT];
	assign last_beat = ~req_block_reg | (beat_reg == sifid_pkg::SIFID_LAST_BEAT);
	assign REQ_READY = (state_reg == sifid_pkg::SIFID_TX_IDLE);
	assign WDATA_TAKE = (state_reg == sifid_pkg::SIFID_TX_DATA);
	assign cmd_prop = req_block_reg ? sifid_pkg::SIFID_PROP_BLOCK : sifid_pkg::SIFID_PROP_WORD;
	assign cmd_size = req_block_reg ? sifid_pkg::SIFID_BLOCK_CODE : {1'b0, req_size_reg};
	assign cmd_word = {1'b0, req_write_reg ? sifid_pkg::SIFID_TYPE_WRITE : sifid_pkg::SIFID_TYPE_READ,
		cmd_prop, cmd_size};
	// Reserved low identifier bits are left at zero by this end
	assign ident_word = {1'b1, ~last_beat, 1'b1, WDATA_PERR, 5'h00};

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			sifid_pkg::SIFID_TX_IDLE: begin
				if (REQ_VALID) begin
					state_next = sifid_pkg::SIFID_TX_CMD;
				end
			end
			sifid_pkg::SIFID_TX_CMD: begin
				state_next = req_write_reg ? sifid_pkg::SIFID_TX_DATA : sifid_pkg::SIFID_TX_IDLE;
			end
			sifid_pkg::SIFID_TX_DATA: begin
				if (paced) begin
					state_next = sifid_pkg::SIFID_TX_GAP;
				end else if (last_beat) begin
					state_next = sifid_pkg::SIFID_TX_IDLE;
				end
			end
			sifid_pkg::SIFID_TX_GAP: begin
				if (gap_reg == sifid_pkg::SIFID_GAP_LAST) begin
					state_next = (beat_reg == 3'h0) ? sifid_pkg::SIFID_TX_IDLE : sifid_pkg::SIFID_TX_DATA;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			state_reg <= sifid_pkg::SIFID_TX_IDLE;
			req_write_reg <= 1'b0;
			req_block_reg <= 1'b0;
			req_size_reg <= 2'h0;
			addr_reg <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			if (REQ_VALID && REQ_READY) begin
				req_write_reg <= REQ_WRITE;
				req_block_reg <= REQ_BLOCK;
				req_size_reg <= REQ_SIZE;
				addr_reg <= addr_aligned;
			end
		end
	end

	// Beat counter wraps to zero after the eighth beat, which ends a paced block
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			beat_reg <= 3'h0;
			gap_reg <= 2'h0;
		end else begin
			if (state_reg == sifid_pkg::SIFID_TX_IDLE) begin
				beat_reg <= 3'h0;
			end else if (state_reg == sifid_pkg::SIFID_TX_DATA) begin
				beat_reg <= beat_reg + 3'h1;
			end
			gap_reg <= (state_reg == sifid_pkg::SIFID_TX_GAP) ? gap_reg + 2'h1 : 2'h0;
		end
	end

	// Pin drivers are registered so the bus never sees decode glitches
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			VALID_OUT_N <= 1'b1;
			CMD_OUT <= 9'h000;
			AD_OUT <= 32'h00000000;
			CHK_OUT <= 4'h0;
			CMD_OE <= 1'b0;
		end else begin
			VALID_OUT_N <= ~(state_reg == sifid_pkg::SIFID_TX_CMD || state_reg == sifid_pkg::SIFID_TX_DATA);
			CMD_OE <= (state_reg == sifid_pkg::SIFID_TX_CMD || state_reg == sifid_pkg::SIFID_TX_DATA);
			if (state_reg == sifid_pkg::SIFID_TX_CMD) begin
				CMD_OUT <= cmd_word;
				AD_OUT <= addr_reg;
				CHK_OUT <= 4'h0;
			end else if (state_reg == sifid_pkg::SIFID_TX_DATA) begin
				CMD_OUT <= ident_word;
				AD_OUT <= WDATA_IN;
				CHK_OUT <= tx_check;
			end
		end
	end

	assign AD_OE = CMD_OE;
	assign CHK_OE = CMD_OE;

	// ****************
	// Receive path
	// ****************
	logic v_s1_reg;
	logic v_s2_reg;
	logic [8:0] cmd_s1_reg;
	logic [8:0] cmd_s2_reg;
	logic [31:0] ad_s1_reg;
	logic [31:0] ad_s2_reg;
	logic [3:0] chk_s1_reg;
	logic [3:0] chk_s2_reg;
	logic rx_beat;
	logic rx_null;
	logic rx_more;
	logic [3:0] rx_check;
	logic ge_d1_reg;
	logic ge_d2_reg;
	logic gb_d1_reg;
	logic gb_d2_reg;
	logic ck_d1_reg;
	logic ck_d2_reg;
	logic ck_d3_reg;
	logic cb_d1_reg;
	logic cb_d2_reg;
	logic cb_d3_reg;
	logic rx_in_block;

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			v_s1_reg <= 1'b0;
			v_s2_reg <= 1'b0;
			cmd_s1_reg <= 9'h000;
			cmd_s2_reg <= 9'h000;
			ad_s1_reg <= 32'h00000000;
			ad_s2_reg <= 32'h00000000;
			chk_s1_reg <= 4'h0;
			chk_s2_reg <= 4'h0;
		end else begin
			v_s1_reg <= ~VALID_IN_N;
			v_s2_reg <= v_s1_reg;
			cmd_s1_reg <= CMD_IN;
			cmd_s2_reg <= cmd_s1_reg;
			ad_s1_reg <= AD_IN;
			ad_s2_reg <= ad_s1_reg;
			chk_s1_reg <= CHK_IN;
			chk_s2_reg <= chk_s1_reg;
		end
	end

	sifid_parity u_rx_parity (
		.data(ad_s2_reg),
		.check(rx_check)
	);

	// Nothing on the bus is looked at unless the agent's valid is asserted
	assign rx_beat = v_s2_reg & cmd_s2_reg[sifid_pkg::SIFID_BIT_IDENT];
	assign rx_null = v_s2_reg & ~cmd_s2_reg[sifid_pkg::SIFID_BIT_IDENT]
		& (cmd_s2_reg[7:5] == sifid_pkg::SIFID_TYPE_NULL)
		& (cmd_s2_reg[4:3] == sifid_pkg::SIFID_PROP_RELEASE);
	assign rx_more = cmd_s2_reg[sifid_pkg::SIFID_BIT_FINAL];
	// A beat belongs to a refill if it is a response and not a lone final beat
	assign rx_in_block = ~cmd_s2_reg[sifid_pkg::SIFID_BIT_RESP] & (rx_more | rx_block_reg);

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RX_VALID <= 1'b0;
			RX_DATA <= 32'h00000000;
			RX_LAST <= 1'b0;
			RX_RESP <= 1'b0;
			IF_RELEASE <= 1'b0;
			rx_block_reg <= 1'b0;
		end else begin
			RX_VALID <= rx_beat;
			IF_RELEASE <= rx_null;
			if (rx_beat) begin
				RX_DATA <= ad_s2_reg;
				RX_LAST <= ~rx_more;
				RX_RESP <= ~cmd_s2_reg[sifid_pkg::SIFID_BIT_RESP];
				rx_block_reg <= rx_in_block & rx_more;
			end
		end
	end

	// Error pipelines: good-data flag after two cycles, check bits after three
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ge_d1_reg <= 1'b0;
			ge_d2_reg <= 1'b0;
			gb_d1_reg <= 1'b0;
			gb_d2_reg <= 1'b0;
			ck_d1_reg <= 1'b0;
			ck_d2_reg <= 1'b0;
			ck_d3_reg <= 1'b0;
			cb_d1_reg <= 1'b0;
			cb_d2_reg <= 1'b0;
			cb_d3_reg <= 1'b0;
		end else begin
			ge_d1_reg <= rx_beat & cmd_s2_reg[sifid_pkg::SIFID_BIT_ERR];
			ge_d2_reg <= ge_d1_reg;
			gb_d1_reg <= rx_beat & rx_in_block;
			gb_d2_reg <= gb_d1_reg;
			ck_d1_reg <= rx_beat & ~cmd_s2_reg[sifid_pkg::SIFID_BIT_CHKEN] & (rx_check != chk_s2_reg);
			ck_d2_reg <= ck_d1_reg;
			ck_d3_reg <= ck_d2_reg;
			cb_d1_reg <= rx_beat & rx_in_block;
			cb_d2_reg <= cb_d1_reg;
			cb_d3_reg <= cb_d2_reg;
		end
	end

	// One error line for both causes; the agent still sends the rest of the block
	assign BUS_ERR = ge_d2_reg | ck_d3_reg;
	assign LINE_INVALID = (ge_d2_reg & gb_d2_reg) | (ck_d3_reg & cb_d3_reg);

	// ****************
	// Checks
	// ****************
	a_null_release: assert property (@(posedge CLK_SYS) disable iff (RST)
		rx_null |=> IF_RELEASE)
		else $error("release null request not flagged");
	a_ident_marks: assert property (@(posedge CLK_SYS) disable iff (RST)
		(state_reg == sifid_pkg::SIFID_TX_DATA) |=> (CMD_OUT[8] && CMD_OE && !VALID_OUT_N))
		else $error("data beat not marked as identifier");
	a_final_beat: assert property (@(posedge CLK_SYS) disable iff (RST)
		(state_reg == sifid_pkg::SIFID_TX_DATA && req_block_reg && beat_reg != 3'h7) |=> CMD_OUT[7])
		else $error("non-final block beat marked final");
	a_write_notresp: assert property (@(posedge CLK_SYS) disable iff (RST)
		(state_reg == sifid_pkg::SIFID_TX_DATA) |=> CMD_OUT[6])
		else $error("write beat marked as response");
	a_perr_mark: assert property (@(posedge CLK_SYS) disable iff (RST)
		(state_reg == sifid_pkg::SIFID_TX_DATA && WDATA_PERR) |=> CMD_OUT[5])
		else $error("parity error beat not marked bad");
	a_word_align: assert property (@(posedge CLK_SYS) disable iff (RST)
		(state_reg == sifid_pkg::SIFID_TX_CMD && (req_block_reg || req_size_reg == 2'h3)) |=> AD_OUT[1:0] == 2'b00)
		else $error("word address not aligned");
	a_half_align: assert property (@(posedge CLK_SYS) disable iff (RST)
		(state_reg == sifid_pkg::SIFID_TX_CMD && !req_block_reg && req_size_reg == 2'h1) |=> !AD_OUT[0])
		else $error("half-word address odd");
	a_reg_readback: assert property (@(posedge CLK_SYS) disable iff (RST)
		(REG_RD && sel_mode) |=> REG_RDATA[19:0] == $past(mode_reg))
		else $error("mode register read mismatch");
	a_pace_gap: assert property (@(posedge CLK_SYS) disable iff (RST)
		(state_reg == sifid_pkg::SIFID_TX_DATA && paced) |=> ##1 (VALID_OUT_N ##1 VALID_OUT_N))
		else $error("paced block beat not followed by two idles");
	a_gooddata_err: assert property (@(posedge CLK_SYS) disable iff (RST)
		(rx_beat && cmd_s2_reg[5]) |-> ##2 BUS_ERR)
		else $error("error data not signalled two cycles later");
	a_check_err: assert property (@(posedge CLK_SYS) disable iff (RST)
		(rx_beat && !cmd_s2_reg[4] && rx_check != chk_s2_reg) |-> ##3 BUS_ERR)
		else $error("check mismatch not signalled three cycles later");
	a_rx_ignore: assert property (@(posedge CLK_SYS) disable iff (RST)
		!v_s2_reg |=> (!RX_VALID && !IF_RELEASE))
		else $error("bus sampled without valid");

	c_block_write: cover property (@(posedge CLK_SYS) disable iff (RST)
		state_reg == sifid_pkg::SIFID_TX_GAP && beat_reg == 3'h0);
	c_refill_error: cover property (@(posedge CLK_SYS) disable iff (RST) LINE_INVALID);
	c_release: cover property (@(posedge CLK_SYS) disable iff (RST) IF_RELEASE);

endmodule : sifid_top

// [bench/sifid_agent.sv]
// External agent model: read responses and interface release requests
`timescale 1ns/1ps
module sifid_agent (
	input wire logic CLK_SYS,
	output logic VALID_IN_N,
	output logic [8:0] CMD_IN,
	output logic [31:0] AD_IN,
	output logic [3:0] CHK_IN
);
	initial begin
		VALID_IN_N = 1'b1;
		CMD_IN = 9'h1FF;
		AD_IN = 32'h0;
		CHK_IN = 4'h0;
	end

	function automatic logic [3:0] par(input logic [31:0] d);
		par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
	endfunction : par

	// Reserved bits 3:0 go out as ones
	function automatic logic [8:0] ident(input logic last, input logic err, input logic nochk);
		ident = {1'b1, ~last, 1'b0, err, nochk, 4'hF};
	endfunction : ident

	task beat(input logic [8:0] cmd, input logic [31:0] d, input logic [3:0] flip);
		@(posedge CLK_SYS);
		VALID_IN_N <= 1'b0;
		CMD_IN <= cmd;
		AD_IN <= d;
		CHK_IN <= par(d) ^ flip;
		@(posedge CLK_SYS);
		VALID_IN_N <= 1'b1;
		// Released lines flip so a stale beat cannot pass for a new one
		CMD_IN <= ~cmd;
		AD_IN <= ~d;
		CHK_IN <= ~(par(d) ^ flip);
	endtask : beat

	// Kind 0 good, 1 error flag, 2 bad check bits, 3 bad check bits with checking off
	task respond(input int n, input int kind, input int eb, input logic [31:0] base);
		for (int k = 0; k < n; k++) begin
			beat(ident(k == n - 1, kind == 1 && k == eb, kind == 3), base + 32'(k), (kind > 1 && k == eb) ? 4'h1 : 4'h0);
		end
	endtask : respond
endmodule : sifid_agent

// [bench/sifid_top_tb_top.sv]
// Self-checking bench for the system interface identifier and error block
`timescale 1ns/1ps
module sifid_top_tb_top;
	logic clk_sys, rst, reg_wr, reg_rd, req_valid, req_write, req_block, wdata_perr, valid_in_n;
	logic req_ready, wdata_take, valid_out_n, cmd_oe, ad_oe, chk_oe, rx_valid, rx_last, rx_resp;
	logic bus_err, line_invalid, if_release;
	logic [35:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, req_addr, wdata_in, ad_in, ad_out, rx_data, d, w;
	logic [1:0] req_size, write_mode;
	logic [8:0] cmd_in, cmd_out;
	logic [3:0] chk_in, chk_out;
	integer seed;
	int n_mismatch, samples_checked, cyc, pin_cyc, src_cyc, rx_cyc, be_cyc, rel_cyc, n_rx, n_be, n_li, n_rel;

	sifid_top sifid_top_i (.CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REQ_VALID(req_valid), .REQ_READY(req_ready),
		.REQ_WRITE(req_write), .REQ_BLOCK(req_block), .REQ_SIZE(req_size), .REQ_ADDR(req_addr),
		.WDATA_IN(wdata_in), .WDATA_PERR(wdata_perr), .WDATA_TAKE(wdata_take), .WRITE_MODE(write_mode),
		.VALID_IN_N(valid_in_n), .CMD_IN(cmd_in), .AD_IN(ad_in), .CHK_IN(chk_in), .VALID_OUT_N(valid_out_n),
		.CMD_OUT(cmd_out), .CMD_OE(cmd_oe), .AD_OUT(ad_out), .AD_OE(ad_oe), .CHK_OUT(chk_out), .CHK_OE(chk_oe),
		.RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_LAST(rx_last), .RX_RESP(rx_resp), .BUS_ERR(bus_err),
		.LINE_INVALID(line_invalid), .IF_RELEASE(if_release));

	sifid_agent sifid_agent_i (.CLK_SYS(clk_sys), .VALID_IN_N(valid_in_n), .CMD_IN(cmd_in), .AD_IN(ad_in),
		.CHK_IN(chk_in));

	// ****************
	// Clock, counters and monitor
	// ****************
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) cyc <= cyc + 1;

	always @(negedge clk_sys) begin
		if (valid_in_n === 1'b0) begin
			pin_cyc = cyc;
			if (cmd_in[8] === 1'b1 && (cmd_in[5] === 1'b1 || (cmd_in[4] === 1'b0 && chk_in !== sifid_agent_i.par(ad_in))))
				src_cyc = cyc;
		end
		if (rx_valid === 1'b1) begin
			n_rx++;
			rx_cyc = cyc;
		end
		if (bus_err === 1'b1) begin
			n_be++;
			be_cyc = cyc;
		end
		if (line_invalid === 1'b1 && bus_err === 1'b1) n_li++;
		if (if_release === 1'b1) begin
			n_rel++;
			rel_cyc = cyc;
		end
	end

	// ****************
	// Tasks
	// ****************
	task chk(input logic [35:0] got, input logic [35:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	task clr;
		n_rx = 0;
		n_be = 0;
		n_li = 0;
		n_rel = 0;
	endtask : clr

	task reg_write(input logic [35:0] a, input logic [31:0] w);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write

	task reg_read(input logic [35:0] a, output logic [31:0] r);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		r = reg_rdata;
	endtask : reg_read

	function automatic logic [31:0] align(input logic [31:0] a, input logic blk, input logic [1:0] sz);
		align = (blk || sz == 2'h3) ? {a[31:2], 2'h0} : (sz == 2'h1) ? {a[31:1], 1'b0} : a;
	endfunction : align

	// One processor request; a read is answered by the agent
	// Automatic so that the capture queues start empty on every call
	task automatic xfer(input logic wr, input logic blk, input logic [1:0] sz, input logic rate, input int kind,
		input int eb);
		logic [8:0] cq[$];
		logic [35:0] aq[$];
		logic [32:0] wq[$];
		int tq[$];
		int n;
		logic [31:0] a;
		a = $random(seed);
		n = wr ? (blk ? 8 : 1) : 0;
		reg_write(sifid_pkg::SIFID_MODE_ADDR, {28'hFFFFFFF, 3'h0, rate});
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_write <= wr;
		req_block <= blk;
		req_size <= sz;
		req_addr <= a;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		repeat (40) begin
			@(negedge clk_sys);
			chk({35'h0, cmd_oe & ad_oe & chk_oe}, {35'h0, ~valid_out_n});
			if (valid_out_n === 1'b0) begin
				cq.push_back(cmd_out);
				aq.push_back({chk_out, ad_out});
				tq.push_back(cyc);
			end
			if (wdata_take === 1'b1) wq.push_back({wdata_perr, wdata_in});
			@(posedge clk_sys);
			wdata_in <= $random(seed);
			wdata_perr <= 1'($random(seed));
		end
		chk({35'h0, req_ready}, 36'h1);
		chk(36'(cq.size()), 36'(n + 1));
		chk(36'(wq.size()), 36'(n));
		chk({27'h0, cq[0]}, {28'h0, wr ? 3'h2 : 3'h0, blk ? 2'h2 : 2'h3, blk ? 3'h1 : {1'b0, sz}});
		chk(aq[0], {4'h0, align(a, blk, sz)});
		for (int k = 1; k <= n; k++) begin
			chk({32'h0, cq[k][8:5]}, {32'h0, 1'b1, k != n, 1'b1, wq[k - 1][32]});
			chk(aq[k], {sifid_agent_i.par(wq[k - 1][31:0]), wq[k - 1][31:0]});
			if (k > 1) chk(36'(tq[k] - tq[k - 1]), rate ? 36'h3 : 36'h1);
		end
		if (!wr) begin
			n = blk ? 8 : 1;
			// A single read has only beat zero to spoil
			eb = eb % n;
			clr();
			sifid_agent_i.respond(n, kind, eb, a);
			repeat (8) @(negedge clk_sys);
			chk(36'(n_rx), 36'(n));
			chk({2'h0, rx_last, rx_resp, rx_data}, {2'h0, 2'h3, a + 32'(n - 1)});
			chk(36'(rx_cyc - pin_cyc), 36'h3);
			chk(36'(n_be), (kind == 1 || kind == 2) ? 36'h1 : 36'h0);
			if (n_be == 1) begin
				chk(36'(be_cyc - src_cyc), kind == 1 ? 36'h4 : 36'h5);
				chk(36'(n_li), 36'(blk));
			end
		end
	endtask : xfer

	// ****************
	// Main sequence
	// ****************
	initial begin
		seed = 32'hC216;
		{reg_wr, reg_rd, req_valid, req_write, req_block, wdata_perr} = 6'h0;
		{reg_addr, reg_wdata, req_addr, wdata_in, req_size} = 134'h0;
		rst = 1'b1;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		reg_read(sifid_pkg::SIFID_MODE_ADDR, d);
		chk({4'h0, d}, 36'h0FFFFFFF0);
		chk({34'h0, write_mode}, 36'h0);
		for (int m = 0; m < 4; m++) begin
			w = {28'hFFFFFFF, 1'b0, 2'(m), 1'($random(seed))};
			reg_write(sifid_pkg::SIFID_MODE_ADDR, w);
			reg_read(sifid_pkg::SIFID_MODE_ADDR, d);
			chk({4'h0, d}, {4'h0, w});
			chk({34'h0, write_mode}, 36'(m));
		end
		reg_read(36'hFFF100008, d);
		chk({4'h0, d}, 36'h0);
		reg_read(sifid_pkg::SIFID_STAT_ADDR, d);
		chk({4'h0, d}, 36'h0);
		xfer(1'b1, 1'b1, 2'h3, 1'b1, 0, 0);
		xfer(1'b1, 1'b1, 2'h0, 1'b0, 0, 0);
		xfer(1'b0, 1'b1, 2'h3, 1'b0, 1, 7);
		xfer(1'b0, 1'b1, 2'h3, 1'b0, 2, 0);
		xfer(1'b0, 1'b0, 2'h1, 1'b0, 3, 0);
		repeat (16) xfer(1'($random(seed)), 1'($random(seed)), 2'($random(seed)), 1'($random(seed)),
			int'($unsigned($random(seed)) % 4), int'($unsigned($random(seed)) % 8));
		clr();
		sifid_agent_i.beat(9'h067, 32'h0, 4'h0);
		repeat (6) @(negedge clk_sys);
		chk(36'(n_rel), 36'h1);
		chk(36'(rel_cyc - pin_cyc), 36'h3);
		chk(36'(n_rx), 36'h0);
		clr();
		sifid_agent_i.beat(9'h06F, 32'h0, 4'h0);
		repeat (6) @(negedge clk_sys);
		chk(36'(n_rel), 36'h0);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		reg_read(sifid_pkg::SIFID_MODE_ADDR, d);
		chk({4'h0, d}, 36'h0FFFFFFF0);
		conclude();
	end

	// A hang ends the run through the same verdict
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		conclude();
	end
endmodule : sifid_top_tb_top
